// ---- core/io_channel_pkg.sv ----
package io_channel_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses, one aligned word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_RESULT = 8'h08;

	// Control word fields
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_ARG_LSB = 8;

	// Status word fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_TIMEOUT_BIT = 1;
	localparam int STAT_DONE_BIT = 2;
	localparam int STAT_ATTN_BIT = 3;

	// Result word fields
	localparam int RES_STATUS_LSB = 0;
	localparam int RES_DEVNUM_LSB = 8;
	localparam int RES_COND_LSB = 16;

	// Reset values
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int TIMEOUT_US = 50;
	localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ;
	localparam int CLEAR_US = 1;
	localparam int CLEAR_CYCLES = CLEAR_US * CLK_MHZ;

	// ----------------------------------------------------------------
	// Orders, exchanges and phases
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_NONE,
		OP_SELECT,
		OP_STATUS,
		OP_COMMAND,
		OP_ACK,
		OP_CLEAR
	} op_e;

	typedef enum logic [1:0] {
		XCH_SELECT,
		XCH_STATUS,
		XCH_COMMAND,
		XCH_ACK
	} xch_e;

	typedef enum logic [2:0] {
		PH_IDLE,
		PH_SETUP,
		PH_STROBE,
		PH_RELEASE,
		PH_CLEAR
	} phase_e;

	// Lines from the channel to the controllers
	typedef struct packed {
		logic [7:0] host_to_device_lines;
		logic select_strobe;
		logic status_request_line;
		logic command_strobe;
		logic interrupt_acknowledge;
		logic system_clear;
	} host_pins_s;

	// Lines from the controllers to the channel
	typedef struct packed {
		logic [7:0] device_to_host_lines;
		logic sync_response;
		logic attention_request;
	} dev_pins_s;

endpackage : io_channel_pkg

// ---- core/io_sync2.sv ----
`timescale 1ns/1ps
module io_sync2 #(
	parameter int WIDTH = 10
) (
	input wire logic clk_in, // Clock
	input wire logic rst_in, // Async reset, active high
	input wire logic ce_in, // Clock enable
	input wire logic [WIDTH-1:0] async_in, // Pin levels
	output logic [WIDTH-1:0] sync_out // Synchronised levels
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// ----------------------------------------------------------------
	// Two flip-flops per bit; the first is read only by the second
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk_in or posedge rst_in) begin
				if (rst_in) begin
					meta_reg[i] <= 1'b0;
					sync_reg[i] <= 1'b0;
				end else if (ce_in) begin
					meta_reg[i] <= async_in[i];
					sync_reg[i] <= meta_reg[i];
				end
			end
		end
	endgenerate

	assign sync_out = sync_reg;

endmodule : io_sync2

// ---- core/io_channel_host.sv ----
`timescale 1ns/1ps
module io_channel_host
	import io_channel_pkg::*;
#(
	parameter int TIMEOUT_CYC = TIMEOUT_CYCLES,
	parameter int CLEAR_CYC = CLEAR_CYCLES
) (
	input wire logic MCLK_IN, // 100 MHz clock
	input wire logic RST_IN, // Async reset, active high
	input wire logic CE_IN, // Clock enable, freezes all state when low
	input wire logic HSEL_IN, // AHB slave select
	input wire logic [31:0] HADDR_IN, // AHB address
	input wire logic [1:0] HTRANS_IN, // AHB transfer type
	input wire logic HWRITE_IN, // AHB write
	input wire logic [2:0] HSIZE_IN, // AHB size
	input wire logic [31:0] HWDATA_IN, // AHB write data
	input wire logic HREADY_IN, // AHB bus ready
	output logic [31:0] HRDATA_OUT, // AHB read data
	output logic HREADYOUT_OUT, // AHB slave ready
	output logic HRESP_OUT, // AHB response, always OKAY
	output io_channel_pkg::host_pins_s BUS_OUT, // Lines toward the controllers
	input wire io_channel_pkg::dev_pins_s BUS_IN // Lines from the controllers
);

	localparam int CW = $clog2(TIMEOUT_CYC + CLEAR_CYC + 1);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	dev_pins_s pins_s;

	io_sync2 #(.WIDTH($bits(dev_pins_s))) u_sync (
		.clk_in(MCLK_IN),
		.rst_in(RST_IN),
		.ce_in(CE_IN),
		.async_in(BUS_IN),
		.sync_out(pins_s)
	);

	wire sync_w = pins_s.sync_response;

	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------
	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;

	wire addr_phase_w = HSEL_IN && HREADY_IN && HTRANS_IN[1];
	wire wr_start_w = addr_phase_w && HWRITE_IN;
	wire rd_start_w = addr_phase_w && !HWRITE_IN;
	wire wr_ctrl_w = CE_IN && wr_pend_reg && (wr_addr_reg == ADDR_CTRL);
	wire wr_stat_w = CE_IN && wr_pend_reg && (wr_addr_reg == ADDR_STAT);

	// ----------------------------------------------------------------
	// Sequencer state
	// ----------------------------------------------------------------
	phase_e phase_reg;
	phase_e phase_next;
	xch_e xch_reg;
	xch_e xch_next;
	op_e op_reg;
	logic [7:0] arg_reg;
	logic [7:0] lines_reg;
	logic [7:0] status_byte_reg;
	logic [7:0] devnum_reg;
	logic [3:0] cond_reg;
	logic [CW-1:0] cnt_reg;
	logic timeout_reg;
	logic done_reg;

	wire busy_w = (phase_reg != PH_IDLE);
	wire [2:0] wr_op_w = HWDATA_IN[CTRL_OP_LSB +: 3];
	wire start_w = wr_ctrl_w && !busy_w && (wr_op_w != 3'(OP_NONE)) && (wr_op_w <= 3'(OP_CLEAR));
	wire expired_w = (cnt_reg >= CW'(TIMEOUT_CYC - 1));
	wire clear_end_w = (cnt_reg >= CW'(CLEAR_CYC - 1));
	wire strobe_ack_w = (phase_reg == PH_STROBE) && sync_w;
	wire release_ok_w = (phase_reg == PH_RELEASE) && !sync_w;
	wire tmo_evt_w = ((phase_reg == PH_STROBE) && !sync_w && expired_w) ||
		((phase_reg == PH_RELEASE) && sync_w && expired_w);

	// Exchange that follows the one just closed, if any
	function automatic logic [2:0] follow(input op_e op, input xch_e x);
		logic [2:0] r;
		r = 3'b000;
		unique case (x)
			XCH_ACK: r = {1'b1, XCH_SELECT};
			XCH_SELECT: begin
				if (op == OP_STATUS || op == OP_ACK)
					r = {1'b1, XCH_STATUS};
				else if (op == OP_COMMAND)
					r = {1'b1, XCH_COMMAND};
			end
			XCH_STATUS, XCH_COMMAND: r = 3'b000;
		endcase
		return r;
	endfunction : follow

	wire [2:0] after_w = follow(op_reg, xch_reg);
	wire more_w = after_w[2];

	// First exchange of an order
	wire xch_e first_w = (op_e'(wr_op_w) == OP_ACK) ? XCH_ACK : XCH_SELECT;

	always_comb begin
		phase_next = phase_reg;
		xch_next = xch_reg;
		unique case (phase_reg)
			PH_IDLE: begin
				if (start_w) begin
					phase_next = (op_e'(wr_op_w) == OP_CLEAR) ? PH_CLEAR : PH_SETUP;
					xch_next = first_w;
				end
			end
			PH_SETUP: phase_next = PH_STROBE;
			PH_STROBE: begin
				if (sync_w)
					phase_next = PH_RELEASE;
				else if (expired_w)
					phase_next = PH_IDLE;
			end
			PH_RELEASE: begin
				if (!sync_w && more_w) begin
					phase_next = PH_SETUP;
					xch_next = xch_e'(after_w[1:0]);
				end else if (!sync_w || expired_w)
					phase_next = PH_IDLE;
			end
			PH_CLEAR: begin
				if (clear_end_w)
					phase_next = PH_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Sequencer registers
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			phase_reg <= PH_IDLE;
			xch_reg <= XCH_SELECT;
			op_reg <= OP_NONE;
			arg_reg <= RESET_BYTE;
			cnt_reg <= '0;
		end else if (CE_IN) begin
			phase_reg <= phase_next;
			xch_reg <= xch_next;
			cnt_reg <= (phase_next != phase_reg) ? '0 : cnt_reg + CW'(1);
			if (start_w) begin
				op_reg <= op_e'(wr_op_w);
				arg_reg <= HWDATA_IN[CTRL_ARG_LSB +: 8];
			end
		end
	end

	// Byte placed on the lines: device number for select, command byte
	// for command; removed when the strobe drops.
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			lines_reg <= RESET_BYTE;
		end else if (CE_IN) begin
			if (phase_next == PH_SETUP && xch_next == XCH_SELECT)
				lines_reg <= (op_reg == OP_ACK && phase_reg != PH_IDLE) ? devnum_reg :
					(phase_reg == PH_IDLE ? HWDATA_IN[CTRL_ARG_LSB +: 8] : arg_reg);
			else if (phase_next == PH_SETUP && xch_next == XCH_COMMAND)
				lines_reg <= arg_reg;
			else if (phase_next != PH_STROBE)
				lines_reg <= RESET_BYTE;
		end
	end

	// Captured answers. Status bits are numbered from the top of the byte,
	// so bits 4 to 7 are the low nibble that holds the busy/end conditions.
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			status_byte_reg <= RESET_BYTE;
			devnum_reg <= RESET_BYTE;
			cond_reg <= 4'h0;
		end else if (CE_IN && strobe_ack_w) begin
			if (xch_reg == XCH_STATUS) begin
				status_byte_reg <= pins_s.device_to_host_lines;
				cond_reg <= pins_s.device_to_host_lines[3:0];
			end
			if (xch_reg == XCH_ACK)
				devnum_reg <= pins_s.device_to_host_lines;
		end
	end

	// Sticky flags; a setting event wins over a write-one clear
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			timeout_reg <= 1'b0;
			done_reg <= 1'b0;
		end else if (CE_IN) begin
			if (tmo_evt_w)
				timeout_reg <= 1'b1;
			else if (wr_stat_w && HWDATA_IN[STAT_TIMEOUT_BIT])
				timeout_reg <= 1'b0;
			if (busy_w && phase_next == PH_IDLE)
				done_reg <= 1'b1;
			else if (wr_stat_w && HWDATA_IN[STAT_DONE_BIT])
				done_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Bus outputs
	// ----------------------------------------------------------------
	wire strobing_w = (phase_reg == PH_STROBE);

	assign BUS_OUT.host_to_device_lines = lines_reg;
	assign BUS_OUT.select_strobe = strobing_w && (xch_reg == XCH_SELECT);
	assign BUS_OUT.status_request_line = strobing_w && (xch_reg == XCH_STATUS);
	assign BUS_OUT.command_strobe = strobing_w && (xch_reg == XCH_COMMAND);
	assign BUS_OUT.interrupt_acknowledge = strobing_w && (xch_reg == XCH_ACK);
	assign BUS_OUT.system_clear = (phase_reg == PH_CLEAR);

	// ----------------------------------------------------------------
	// Register read mux and AHB data phase
	// ----------------------------------------------------------------
	logic [31:0] stat_word_w;
	logic [31:0] result_word_w;

	always_comb begin
		stat_word_w = '0;
		stat_word_w[STAT_BUSY_BIT] = busy_w;
		stat_word_w[STAT_TIMEOUT_BIT] = timeout_reg;
		stat_word_w[STAT_DONE_BIT] = done_reg;
		stat_word_w[STAT_ATTN_BIT] = pins_s.attention_request;
		result_word_w = '0;
		result_word_w[RES_STATUS_LSB +: 8] = status_byte_reg;
		result_word_w[RES_DEVNUM_LSB +: 8] = devnum_reg;
		result_word_w[RES_COND_LSB +: 4] = cond_reg;
		unique case (HADDR_IN[7:0])
			ADDR_CTRL: rdata_next = {16'h0000, arg_reg, 5'h00, op_reg};
			ADDR_STAT: rdata_next = stat_word_w;
			ADDR_RESULT: rdata_next = result_word_w;
			default: rdata_next = '0;
		endcase
		if (HADDR_IN[31:8] != 24'h000000)
			rdata_next = '0;
	end

	// Zero wait states: read data is snapped in the address phase
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			rdata_reg <= '0;
		end else if (CE_IN) begin
			if (HREADY_IN) begin
				wr_pend_reg <= wr_start_w && (HADDR_IN[31:8] == 24'h000000);
				wr_addr_reg <= HADDR_IN[7:0];
			end
			if (rd_start_w)
				rdata_reg <= rdata_next;
		end
	end

	assign HRDATA_OUT = rdata_reg;
	assign HREADYOUT_OUT = 1'b1;
	assign HRESP_OUT = 1'b0;

endmodule : io_channel_host

// ---- testbench/io_channel_host_assertions.sv ----
`timescale 1ns/1ps
module io_channel_host_checker
	import io_channel_pkg::*;
#(
	parameter int TIMEOUT_CYC = TIMEOUT_CYCLES
) (
	input wire logic MCLK_IN, // Clock
	input wire logic RST_IN, // Reset
	input wire io_channel_pkg::host_pins_s BUS_OUT, // Lines out
	input wire io_channel_pkg::dev_pins_s BUS_IN // Lines in
);
	default clocking @(posedge MCLK_IN); endclocking
	default disable iff (RST_IN);
	wire logic strb = BUS_OUT.select_strobe | BUS_OUT.status_request_line |
		BUS_OUT.command_strobe | BUS_OUT.interrupt_acknowledge;
	logic seen_reg;
	int cnt_reg;
	// Strobe age and whether sync came, so a drop can be traced to its cause
	always_ff @(posedge MCLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			seen_reg <= 1'h0;
			cnt_reg <= 0;
		end else if (!strb) begin
			seen_reg <= 1'h0;
			cnt_reg <= 0;
		end else begin
			seen_reg <= seen_reg | BUS_IN.sync_response;
			cnt_reg <= cnt_reg + 1;
		end
	end
	property p_one; $onehot0({strb, BUS_OUT.system_clear}) &&
		$onehot0({BUS_OUT.select_strobe, BUS_OUT.status_request_line,
		BUS_OUT.command_strobe, BUS_OUT.interrupt_acknowledge}); endproperty
	a_one: assert property (p_one) else $error("two requests at once");
	property p_setup; $rose(BUS_OUT.command_strobe) |->
		$stable(BUS_OUT.host_to_device_lines); endproperty
	a_setup: assert property (p_setup) else $error("byte not set up");
	property p_hold; $fell(strb) |-> $past(seen_reg) ||
		$past(cnt_reg) >= TIMEOUT_CYC - 3; endproperty
	a_hold: assert property (p_hold) else $error("strobe dropped early");
	property p_tmo; cnt_reg <= TIMEOUT_CYC + 2; endproperty
	a_tmo: assert property (p_tmo) else $error("no timeout");
	property p_sr; BUS_OUT.status_request_line && BUS_IN.sync_response |->
		##[1:5] !BUS_OUT.status_request_line; endproperty
	a_sr: assert property (p_sr) else $error("status request held");
	property p_cmd; BUS_OUT.command_strobe && BUS_IN.sync_response |->
		##[1:5] (!BUS_OUT.command_strobe && BUS_OUT.host_to_device_lines == 8'h00);
	endproperty
	a_cmd: assert property (p_cmd) else $error("command not removed");
	property p_ack; BUS_OUT.interrupt_acknowledge && BUS_IN.sync_response |->
		##[1:5] !BUS_OUT.interrupt_acknowledge; endproperty
	a_ack: assert property (p_ack) else $error("acknowledge held");
	property p_gap; BUS_IN.sync_response |=> !$rose(strb); endproperty
	a_gap: assert property (p_gap) else $error("request before sync low");
endmodule : io_channel_host_checker
bind io_channel_host io_channel_host_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk_i (
	.MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .BUS_OUT(BUS_OUT), .BUS_IN(BUS_IN));

// ---- testbench/io_ctrl_model.sv ----
`timescale 1ns/1ps
module io_ctrl_model
	import io_channel_pkg::*;
#(
	parameter logic [7:0] DEV_NUM = 8'h22
) (
	input wire logic clk_in, // Sampling clock
	input wire io_channel_pkg::host_pins_s pins_in, // Channel lines
	input wire logic [7:0] status_in, // Status byte
	input wire logic irq_in, // Device interrupt event
	output io_channel_pkg::dev_pins_s pins_out, // Lines to channel
	output logic ack_out, // Acknowledge onward
	output logic [7:0] cmd_out, // Command register
	output logic sel_out // Selected flag
);
	logic iflag = 1'h0;
	logic answered = 1'h0;
	logic [7:0] last = 8'h00;
	wire logic hit = pins_in.select_strobe && pins_in.host_to_device_lines == DEV_NUM;
	wire logic give_st = sel_out && pins_in.status_request_line;
	wire logic give_num = iflag && pins_in.interrupt_acknowledge;
	wire logic take_cmd = sel_out && pins_in.command_strobe;
	initial sel_out = 1'h0;
	initial cmd_out = 8'h00;
	assign ack_out = pins_in.interrupt_acknowledge && !iflag;
	assign pins_out.sync_response = hit || give_st || give_num || take_cmd;
	assign pins_out.attention_request = iflag && !answered;
	// Released lines show the inverse of the last byte so stale data cannot pass
	assign pins_out.device_to_host_lines = give_st ? status_in :
		give_num ? DEV_NUM : ~last;
	always @(posedge clk_in) begin
		if (give_st || give_num)
			last <= pins_out.device_to_host_lines;
		if (pins_in.system_clear || (pins_in.select_strobe && !hit))
			sel_out <= 1'h0;
		else if (hit)
			sel_out <= 1'h1;
		if (take_cmd)
			cmd_out <= pins_in.host_to_device_lines;
		if (give_num)
			answered <= 1'h1;
		if (pins_in.system_clear || (answered && !give_num)) begin
			iflag <= 1'h0;
			answered <= 1'h0;
		end else if (irq_in)
			iflag <= 1'h1;
	end
endmodule : io_ctrl_model

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	import io_channel_pkg::*;
	typedef struct packed {logic [2:0] op; logic [7:0] arg; logic [7:0] sb; logic to;} row_s;
	localparam logic [7:0] DEV = 8'h22;
	logic clk = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0, irq = 1'h0, rdy, resp, sel;
	logic ce = 1'h1;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
	logic [7:0] sb = 8'h00, cmd;
	host_pins_s hp;
	dev_pins_s dp;
	int mismatches = 0, n_compared = 0;
	row_s rows [6] = '{'{3'h1, DEV, 8'h00, 1'h0}, '{3'h2, DEV, 8'ha5, 1'h0},
		'{3'h2, DEV, 8'h5a, 1'h0}, '{3'h3, DEV, 8'h00, 1'h0},
		'{3'h1, 8'h33, 8'h00, 1'h1}, '{3'h2, 8'h33, 8'h00, 1'h1}};
	io_channel_host #(.TIMEOUT_CYC(40), .CLEAR_CYC(4)) io_channel_host_i (.MCLK_IN(clk),
		.RST_IN(rst), .CE_IN(ce), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
		.HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(rdy),
		.HRDATA_OUT(hrdata), .HREADYOUT_OUT(rdy), .HRESP_OUT(resp), .BUS_OUT(hp), .BUS_IN(dp));
	io_ctrl_model #(.DEV_NUM(DEV)) io_ctrl_model_i (.clk_in(clk), .pins_in(hp),
		.status_in(sb), .irq_in(irq), .pins_out(dp), .ack_out(), .cmd_out(cmd), .sel_out(sel));
	initial forever #5 clk = ~clk;
	task automatic test_done;
		if (mismatches == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic wait_rdy;
		int n;
		n = 0;
		@(posedge clk);
		while (rdy !== 1'h1) begin
			if (++n > 20) begin
				chk("hready", 32'h1, 32'h0);
				test_done();
			end
			@(posedge clk);
		end
		chk("hresp", 32'h0, resp);
	endtask : wait_rdy
	task automatic ahb(input logic wr, input logic [8:0] a, input logic [31:0] wd);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= {23'h0, a};
		hwrite <= wr;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		d = hrdata;
	endtask : ahb
	// Waits on busy rather than a cycle count, since exchange length follows the device
	task automatic run(input logic [2:0] op, input logic [7:0] arg);
		int n;
		ahb(1'h1, ADDR_STAT, 32'h6);
		ahb(1'h1, ADDR_CTRL, {16'h0, arg, 5'h0, op});
		repeat (2) @(posedge clk);
		n = 0;
		d = 32'h1;
		while (d[STAT_BUSY_BIT] !== 1'h0) begin
			if (++n > 200) begin
				chk("busy", 32'h0, 32'h1);
				test_done();
			end
			ahb(1'h0, ADDR_STAT, 32'h0);
		end
	endtask : run
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		foreach (rows[i]) begin
			sb <= rows[i].sb;
			run(rows[i].op, rows[i].arg);
			chk("timeout", rows[i].to, d[STAT_TIMEOUT_BIT]);
			chk("done", 32'h1, d[STAT_DONE_BIT]);
			chk("selected", !rows[i].to, sel);
			if (rows[i].op == 3'h3)
				chk("command", DEV, cmd);
			ahb(1'h0, ADDR_RESULT, 32'h0);
			if (rows[i].op == 3'h2 && !rows[i].to)
				chk("status", {12'h0, rows[i].sb[3:0], 8'h0, rows[i].sb}, d & 32'hf00ff);
		end
		ahb(1'h0, ADDR_CTRL, 32'h0);
		chk("ctrl", {16'h0, 8'h33, 5'h0, 3'h2}, d);
		irq <= 1'h1;
		@(posedge clk);
		irq <= 1'h0;
		sb <= 8'h3c;
		repeat (4) @(posedge clk);
		ahb(1'h0, ADDR_STAT, 32'h0);
		chk("attention", 32'h1, d[STAT_ATTN_BIT]);
		run(OP_ACK, 8'h00);
		repeat (4) @(posedge clk);
		ahb(1'h0, ADDR_RESULT, 32'h0);
		chk("ack result", {12'h0, 4'hc, DEV, 8'h3c}, d);
		ahb(1'h0, ADDR_STAT, 32'h0);
		chk("attention off", 32'h0, d[STAT_ATTN_BIT] | d[STAT_TIMEOUT_BIT]);
		run(OP_ACK, 8'h00);
		chk("ack unanswered", 32'h1, d[STAT_TIMEOUT_BIT]);
		irq <= 1'h1;
		@(posedge clk);
		irq <= 1'h0;
		run(OP_CLEAR, 8'h00);
		repeat (4) @(posedge clk);
		ahb(1'h0, ADDR_STAT, 32'h0);
		chk("clear", 32'h0, {sel, d[STAT_ATTN_BIT]});
		ce <= 1'h0;
		ahb(1'h1, ADDR_CTRL, {16'h0, DEV, 5'h0, 3'h1});
		ce <= 1'h1;
		ahb(1'h0, ADDR_STAT, 32'h0);
		chk("frozen", 32'h0, d[STAT_BUSY_BIT]);
		ahb(1'h0, 9'h100, 32'h0);
		chk("unmapped", 32'h0, d);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		chk("reset bus", 32'h0, hp);
		rst <= 1'h0;
		@(posedge clk);
		ahb(1'h0, ADDR_RESULT, 32'h0);
		chk("reset result", 32'h0, d);
		test_done();
	end
endmodule : testbench
